// file: design/bfh_ctrl.sv
// hop controller: idle-time selection, noise integrators, offset tables
// assumes scan engine supplies deltas, scan end, calibration state, references
`default_nettype none
module bfh_ctrl (
  input  wire logic                                core_clk,   // device clock
  input  wire logic                                rst,        // async reset, high
  input  wire bfh_pkg::bfh_bus_req_type            bus_req,    // setup bus request
  output logic [7:0]                               bus_rdata,  // read data, next cycle
  input  wire bfh_pkg::bfh_delta_type              key_delta,  // one key delta
  input  wire logic                                scan_end,   // end of matrix scan pulse
  input  wire logic                                cal_busy,   // any key calibrating
  input  wire logic [bfh_pkg::KEY_W-1:0]           ref_key,    // key index of ref_value
  input  wire logic [bfh_pkg::REF_W-1:0]           ref_value,  // reference at ref_key
  input  wire logic                                ref_valid,  // ref sample strobe
  input  wire logic [1:0]                          ref_freq,   // setting used for ref
  output logic [bfh_pkg::IDLE_W-1:0]               idle_time,  // active idle time
  output logic                                     hop_pulse,  // hop taken
  output logic                                     recal_all,  // recalibrate all keys
  output logic                                     adj_ref,    // apply offsets now
  output logic [1:0]                               freq_sel,   // active setting index
  input  wire logic [bfh_pkg::KEY_W-1:0]           adj_key,    // key to fetch offset
  output logic [7:0]                               adj_offset, // unsigned, zero at setting 0
  output logic                                     auto_busy   // offset fill running
);
  // ------------------------------------------------------------
  // settings
  // ------------------------------------------------------------
  logic [1:0]                 hop_mode_select_ff;
  logic [bfh_pkg::IDLE_W-1:0] idle_time_primary_ff;
  logic [bfh_pkg::IDLE_W-1:0] idle_time_secondary_ff;
  logic [bfh_pkg::IDLE_W-1:0] idle_time_tertiary_ff;
  logic [3:0]                 noise_delta_threshold_ff;
  logic [3:0]                 noise_count_limit_ff;
  logic [7:0]                 key_offset_table_a [bfh_pkg::KEY_CNT];
  logic [7:0]                 key_offset_table_b [bfh_pkg::KEY_CNT];
  logic [3:0]                 pos_cnt_ff;
  logic [3:0]                 neg_cnt_ff;
  logic [1:0]                 freq_sel_ff;
  logic [bfh_pkg::IDLE_W-1:0] sweep_ff;
  logic [bfh_pkg::REF_W-1:0]  ref_high [bfh_pkg::KEY_CNT];
  logic                       auto_ff;
  logic                       wr_a;
  logic                       wr_b;
  logic [bfh_pkg::KEY_W-1:0]  wr_idx;
  logic                       hopping;
  logic                       hop_now;
  logic                       noisy;
  logic [bfh_pkg::DELTA_W-1:0] thr;
  bfh_pkg::bfh_mode_type      mode;

  function automatic logic in_table(input logic [7:0] a, input logic [7:0] base);
    in_table = (a >= base) && (a < base + bfh_pkg::REG_TBL_SPAN);
  endfunction

  assign mode    = bfh_pkg::bfh_mode_type'(hop_mode_select_ff);
  assign hopping = (mode == bfh_pkg::HOP_RECAL) || (mode == bfh_pkg::HOP_OFFSET); // RQ11
  assign wr_a    = bus_req.wr && in_table(bus_req.addr, bfh_pkg::REG_TBL_A_BASE);
  assign wr_b    = bus_req.wr && in_table(bus_req.addr, bfh_pkg::REG_TBL_B_BASE);
  assign wr_idx  = bus_req.addr[bfh_pkg::KEY_W-1:0] - (bus_req.addr[7] ? 6'h00 : 6'h00);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hop_mode_select_ff <= bfh_pkg::RST_HOP_MODE;
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_HOP_MODE)
    begin
      hop_mode_select_ff <= bus_req.wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_time_primary_ff <= bfh_pkg::RST_IDLE_PRI; // RQ5
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_IDLE_PRI)
    begin
      idle_time_primary_ff <= bus_req.wdata[5:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_time_secondary_ff <= bfh_pkg::RST_IDLE_SEC; // RQ7
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_IDLE_SEC)
    begin
      idle_time_secondary_ff <= bus_req.wdata[5:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_time_tertiary_ff <= bfh_pkg::RST_IDLE_TER; // RQ8
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_IDLE_TER)
    begin
      idle_time_tertiary_ff <= bus_req.wdata[5:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      noise_delta_threshold_ff <= bfh_pkg::RST_NOISE_THR; // RQ10
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_NOISE_THR)
    begin
      noise_delta_threshold_ff <= bus_req.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      noise_count_limit_ff <= bfh_pkg::RST_NOISE_LIM; // RQ15
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_NOISE_LIM)
    begin
      noise_count_limit_ff <= bus_req.wdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // noise integrators
  // ------------------------------------------------------------
  // code n maps to 5 + 3n counts, 5..50
  assign thr = bfh_pkg::THR_BASE + bfh_pkg::THR_STEP * {8'h00, noise_delta_threshold_ff}; // RQ10

  assign noisy = hopping && key_delta.valid && key_delta.mag >= thr; // RQ9

  // saturating, one counter per polarity
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pos_cnt_ff <= 4'h0;
    end
    else if (scan_end)
    begin
      pos_cnt_ff <= 4'h0; // RQ14
    end
    else if (noisy && !key_delta.neg && pos_cnt_ff != 4'hf)
    begin
      pos_cnt_ff <= pos_cnt_ff + 4'h1; // RQ12
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      neg_cnt_ff <= 4'h0;
    end
    else if (scan_end)
    begin
      neg_cnt_ff <= 4'h0; // RQ14
    end
    else if (noisy && key_delta.neg && neg_cnt_ff != 4'hf)
    begin
      neg_cnt_ff <= neg_cnt_ff + 4'h1; // RQ12
    end
  end

  // decided on the counts held at scan end
  assign hop_now = hopping && scan_end && !cal_busy && !auto_ff // RQ23
                   && pos_cnt_ff >= noise_count_limit_ff && neg_cnt_ff >= noise_count_limit_ff; // RQ13

  // ------------------------------------------------------------
  // frequency selection
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      freq_sel_ff <= 2'h0;
    end
    else if (!hopping)
    begin
      freq_sel_ff <= 2'h0;
    end
    else if (hop_now)
    begin
      freq_sel_ff <= (freq_sel_ff == 2'h2) ? 2'h0 : freq_sel_ff + 2'h1; // RQ25
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sweep_ff <= bfh_pkg::RST_IDLE_PRI;
    end
    else if (mode != bfh_pkg::HOP_SWEEP)
    begin
      sweep_ff <= idle_time_primary_ff;
    end
    else if (scan_end) // RQ21
    begin
      sweep_ff <= (sweep_ff >= idle_time_secondary_ff) ? idle_time_primary_ff : sweep_ff + 6'h01; // RQ24
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      idle_time <= bfh_pkg::RST_IDLE_PRI;
    else
    begin
      unique case (mode)
        bfh_pkg::HOP_OFF:   idle_time <= idle_time_primary_ff; // RQ6
        bfh_pkg::HOP_SWEEP: idle_time <= sweep_ff; // RQ2
        default:
        begin
          // idle value feeds the burst gap counter directly
          unique case (freq_sel_ff) // RQ1 RQ4
            2'h1:    idle_time <= idle_time_secondary_ff;
            2'h2:    idle_time <= idle_time_tertiary_ff; // RQ8
            default: idle_time <= idle_time_primary_ff;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hop_pulse <= 1'b0;
    end
    else
    begin
      hop_pulse <= hop_now;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      recal_all <= 1'b0;
    end
    else
    begin
      recal_all <= hop_now && (mode == bfh_pkg::HOP_RECAL); // RQ22
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      adj_ref <= 1'b0;
    end
    else
    begin
      adj_ref <= hop_now && (mode == bfh_pkg::HOP_OFFSET); // RQ16
    end
  end
  assign freq_sel = freq_sel_ff;

  // ------------------------------------------------------------
  // offset tables and automatic fill
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      auto_ff <= 1'b0;
    end
    else if (bus_req.wr && bus_req.addr == bfh_pkg::REG_CMD && bus_req.wdata == bfh_pkg::CMD_AUTO_OFFSET) // RQ18
    begin
      auto_ff <= 1'b1;
    end
    else if (scan_end && !cal_busy)
    begin
      auto_ff <= 1'b0;
    end
  end
  assign auto_busy = auto_ff;

  // references captured at setting 0, the highest frequency
  always_ff @(posedge core_clk)
  begin
    if (auto_ff && ref_valid && ref_freq == 2'h0)
      ref_high[ref_key] <= ref_value; // RQ17
  end

  generate
    for (genvar k = 0; k < bfh_pkg::KEY_CNT; k++)
    begin : g_tbl
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          key_offset_table_a[k] <= bfh_pkg::RST_OFFSET; // RQ19
          key_offset_table_b[k] <= bfh_pkg::RST_OFFSET;
        end
        else if (wr_a && wr_idx == 6'(k))
          key_offset_table_a[k] <= bus_req.wdata;
        else if (wr_b && wr_idx == 6'(k))
          key_offset_table_b[k] <= bus_req.wdata;
        else if (auto_ff && ref_valid && ref_key == 6'(k) && ref_freq != 2'h0)
        begin
          // clamp negative, saturate at 255
          if (ref_high[k] <= ref_value)
          begin
            if (ref_freq == 2'h1) key_offset_table_a[k] <= 8'h00; // RQ19
            else                  key_offset_table_b[k] <= 8'h00;
          end
          else if (ref_freq == 2'h1)
            key_offset_table_a[k] <= (ref_high[k] - ref_value > 16'h00ff) ? 8'hff : 8'(ref_high[k] - ref_value);
          else
            key_offset_table_b[k] <= (ref_high[k] - ref_value > 16'h00ff) ? 8'hff : 8'(ref_high[k] - ref_value);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      adj_offset <= 8'h00;
    end
    else if (freq_sel_ff == 2'h1)
    begin
      adj_offset <= key_offset_table_a[adj_key]; // RQ16
    end
    else if (freq_sel_ff == 2'h2)
    begin
      adj_offset <= key_offset_table_b[adj_key];
    end
    else
    begin
      adj_offset <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bus_rdata <= 8'h00;
    else if (!bus_req.rd)
      bus_rdata <= 8'h00;
    else if (in_table(bus_req.addr, bfh_pkg::REG_TBL_A_BASE))
      bus_rdata <= key_offset_table_a[bus_req.addr[5:0]];
    else if (in_table(bus_req.addr, bfh_pkg::REG_TBL_B_BASE))
      bus_rdata <= key_offset_table_b[bus_req.addr[5:0]];
    else
    begin
      unique case (bus_req.addr)
        bfh_pkg::REG_HOP_MODE:  bus_rdata <= {6'h00, hop_mode_select_ff};
        bfh_pkg::REG_IDLE_PRI:  bus_rdata <= {2'h0, idle_time_primary_ff};
        bfh_pkg::REG_IDLE_SEC:  bus_rdata <= {2'h0, idle_time_secondary_ff};
        bfh_pkg::REG_IDLE_TER:  bus_rdata <= {2'h0, idle_time_tertiary_ff};
        bfh_pkg::REG_NOISE_THR: bus_rdata <= {4'h0, noise_delta_threshold_ff};
        bfh_pkg::REG_NOISE_LIM: bus_rdata <= {4'h0, noise_count_limit_ff};
        bfh_pkg::REG_STATUS:    bus_rdata <= {auto_ff, freq_sel_ff, 5'h00};
        default:                bus_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: inc/bfh_pkg.sv
// package for the burst frequency hop controller: setting layout, defaults, modes
// assumes a single core_clk domain, the device's own reset and an internal setup bus
// Overview of operation
// RQ1 - modes 1, 2 hop among three idle settings
// RQ2 - mode 3 sweeps between primary and secondary
// RQ3 - host sets secondary above primary for sweep
// RQ4 - larger idle value gives longer pulse gap
// RQ5 - primary idle 0 to 63, default 24
// RQ6 - secondary idle ignored when hopping is off
// RQ7 - secondary idle 0 to 63, default 30
// RQ8 - tertiary idle only modes 1, 2, default 36
// RQ9 - delta magnitude at threshold increments integrator
// RQ10 - threshold code 0 to 15 maps 5 to 50
// RQ11 - threshold and limit only in modes 1, 2
// RQ12 - separate positive and negative noise integrators
// RQ13 - hop considered only when both reach limit
// RQ14 - integrators cleared at end of each scan
// RQ15 - limit 0 to 15, default 3, host avoids 0-2
// RQ16 - mode 2 offsets every key reference on hop
// RQ17 - offsets relative to highest frequency, two tables
// RQ18 - command fills offset tables, host may edit
// RQ19 - offset 0 to 255, reference difference clamped at zero
// RQ20 - host ends setups with 16-bit checksum, low first
// RQ21 - sweep steps every scan, no reference adjust
// RQ22 - mode 1 recalibrates all keys after hop
// RQ23 - modes 1, 2 never hop during calibration
// RQ24 - sweep steps by one from primary to secondary
// RQ25 - hops go round robin over three settings
`default_nettype none
package bfh_pkg;
  localparam int KEY_CNT = 48;
  localparam int KEY_W = 6;
  localparam int IDLE_W = 6;
  localparam int DELTA_W = 12;
  localparam int REF_W = 16;
  // register offsets on the setup bus
  localparam logic [7:0] REG_HOP_MODE = 8'h00;
  localparam logic [7:0] REG_IDLE_PRI = 8'h01;
  localparam logic [7:0] REG_IDLE_SEC = 8'h02;
  localparam logic [7:0] REG_IDLE_TER = 8'h03;
  localparam logic [7:0] REG_NOISE_THR = 8'h04;
  localparam logic [7:0] REG_NOISE_LIM = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_CMD = 8'h07;
  localparam logic [7:0] REG_CHECKSUM = 8'h08;
  localparam logic [7:0] REG_TBL_A_BASE = 8'h40;
  localparam logic [7:0] REG_TBL_B_BASE = 8'h80;
  localparam logic [7:0] REG_TBL_SPAN = 8'h30;
  localparam logic [7:0] CMD_AUTO_OFFSET = 8'h02;
  // reset values
  localparam logic [1:0] RST_HOP_MODE = 2'h1;
  localparam logic [IDLE_W-1:0] RST_IDLE_PRI = 6'h18;
  localparam logic [IDLE_W-1:0] RST_IDLE_SEC = 6'h1e;
  localparam logic [IDLE_W-1:0] RST_IDLE_TER = 6'h24;
  localparam logic [3:0] RST_NOISE_THR = 4'h0;
  localparam logic [3:0] RST_NOISE_LIM = 4'h3;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [DELTA_W-1:0] THR_BASE = 12'h005;
  localparam logic [DELTA_W-1:0] THR_STEP = 12'h003;
  typedef enum logic [1:0] {HOP_OFF, HOP_RECAL, HOP_OFFSET, HOP_SWEEP} bfh_mode_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bfh_bus_req_type;
  typedef struct packed {
    logic               valid;
    logic               neg;
    logic [DELTA_W-1:0] mag;
  } bfh_delta_type;
endpackage
`default_nettype wire

// file: testbench/bfh_host_model.sv
// host model: drives the setup bus of the hop controller
// assumes tasks are called from the bench's main sequence
`default_nettype none
module bfh_host_model (
  input  wire logic                     core_clk,  // clock
  input  wire logic [7:0]               bus_rdata, // read data
  output var  bfh_pkg::bfh_bus_req_type bus_req    // bus request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_req = '0;
  logic [15:0] blk_sum = 16'h0000;
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == bfh_pkg::REG_NOISE_LIM && v < 8'h03)
      v = 8'h03;
    blk_sum = blk_sum + {8'h00, v};
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask
  // secondary three above primary for sweep, for lo up to 60
  task automatic sweep_range(input logic [5:0] lo);
    wr(bfh_pkg::REG_IDLE_PRI, {2'b00, lo});
    wr(bfh_pkg::REG_IDLE_SEC, {2'b00, lo} + 8'h03);
  endtask
  // setups block closes with its checksum, low byte first
  task automatic close_block();
    logic [15:0] s;
    s = blk_sum;
    wr(bfh_pkg::REG_CHECKSUM, s[7:0]);
    wr(bfh_pkg::REG_CHECKSUM, s[15:8]);
    blk_sum = 16'h0000;
  endtask
endmodule
`default_nettype wire

// file: testbench/bfh_monitor.sv
// checker: port-level assertions for the hop controller
// assumes it is bound onto bfh_ctrl from the bench top
`default_nettype none
module bfh_monitor (
  input wire logic                     core_clk,   // clock
  input wire logic                     rst,        // reset
  input wire bfh_pkg::bfh_bus_req_type bus_req,    // bus
  input wire logic [7:0]               bus_rdata,  // read data
  input wire logic                     scan_end,   // scan end
  input wire logic                     cal_busy,   // calibrating
  input wire logic [1:0]               freq_sel,   // setting
  input wire logic                     hop_pulse,  // hop
  input wire logic                     recal_all,  // recal
  input wire logic                     adj_ref,    // adjust
  input wire logic [7:0]               adj_offset, // offset
  input wire logic                     auto_busy   // auto fill
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // hop sequences
  // ----------------------------------------
  sequence hop_s;
    hop_pulse ##1 !hop_pulse && $stable(freq_sel);
  endsequence
  sequence take_s;
    hop_pulse && $past(scan_end) && !$past(cal_busy) && !$past(auto_busy);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rdata_idle_a: assert property (bus_rdata != 8'h00 |-> $past(bus_req.rd))
    else $error("read data outside read cycle");
  hop_cause_a: assert property (hop_pulse |-> take_s)
    else $error("hop without clean scan end");
  hop_once_a: assert property (hop_pulse |-> hop_s)
    else $error("hop pulse too long");
  hop_step_a: assert property (hop_pulse |->
    freq_sel == ($past(freq_sel) == 2'h2 ? 2'h0 : $past(freq_sel) + 2'h1))
    else $error("hop not round robin");
  sel_move_a: assert property ($changed(freq_sel) && freq_sel != 2'h0 |-> hop_pulse)
    else $error("setting moved without hop");
  sel_range_a: assert property (freq_sel != 2'h3)
    else $error("setting index out of range");
  pulse_kind_a: assert property ((recal_all || adj_ref) |-> hop_pulse && !(recal_all && adj_ref))
    else $error("recal or adjust without hop");
  hop_kind_a: assert property (hop_pulse |-> (recal_all || adj_ref))
    else $error("hop without follow up");
  base_offset_a: assert property (freq_sel == 2'h0 && $past(freq_sel) == 2'h0 |-> adj_offset == 8'h00)
    else $error("offset at base setting");
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the burst frequency hop controller
// assumes host model and monitor are compiled first
`default_nettype none
bind bfh_ctrl bfh_monitor mon (.core_clk, .rst, .bus_req, .bus_rdata, .scan_end, .cal_busy,
  .freq_sel, .hop_pulse, .recal_all, .adj_ref, .adj_offset, .auto_busy);
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     core_clk, rst, scan_end, cal_busy, ref_valid;
  logic                     hop_pulse, recal_all, adj_ref, auto_busy;
  bfh_pkg::bfh_bus_req_type bus_req;
  bfh_pkg::bfh_delta_type   key_delta;
  logic [7:0]               bus_rdata, adj_offset, rv;
  logic [5:0]               ref_key, adj_key, idle_time;
  logic [15:0]              ref_value;
  logic [1:0]               ref_freq, freq_sel;
  int                       error_cnt, checks_done, cyc, hop_n, rec_n, adj_n;
  int                       lim, thr, m, i, k, a, p, h0;
  logic [7:0]               offs [3];
  logic [7:0]               rstv [6] = '{8'h01, 8'h18, 8'h1e, 8'h24, 8'h00, 8'h03};
  bfh_ctrl DUT (.core_clk, .rst, .bus_req, .bus_rdata, .key_delta, .scan_end, .cal_busy,
    .ref_key, .ref_value, .ref_valid, .ref_freq, .idle_time, .hop_pulse, .recal_all,
    .adj_ref, .freq_sel, .adj_key, .adj_offset, .auto_busy);
  bfh_host_model host (.core_clk, .bus_rdata, .bus_req);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    hop_n <= hop_n + int'(hop_pulse);
    rec_n <= rec_n + int'(recal_all);
    adj_n <= adj_n + int'(adj_ref);
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic scan();
    @(posedge core_clk) scan_end <= 1'b1;
    @(posedge core_clk) scan_end <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic delta(input logic ng, input int mag);
    @(posedge core_clk) key_delta <= '{valid: 1'b1, neg: ng, mag: 12'(mag)};
    @(posedge core_clk) key_delta <= '0;
  endtask
  task automatic ref_sample(input logic [1:0] f, input int v);
    @(posedge core_clk) {ref_valid, ref_freq, ref_value} <= {1'b1, f, 16'(v)};
    @(posedge core_clk) ref_valid <= 1'b0;
  endtask
  task automatic try_hop(input int np, input int nn, input int mag, input logic exp);
    int h;
    int r;
    int j;
    h = hop_n;
    r = rec_n;
    j = adj_n;
    repeat (np) delta(1'b0, mag);
    repeat (nn) delta(1'b1, mag);
    scan();
    chk("hop", 8'(hop_n - h), {7'h00, exp});
    chk("recal", 8'(rec_n - r), {7'h00, exp && m == 1});
    chk("adjust", 8'(adj_n - j), {7'h00, exp && m == 2});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {core_clk, rst, scan_end, cal_busy, ref_valid} = 5'b01000;
    key_delta = '0;
    {ref_freq, ref_value} = '0;
    void'($urandom(32'hb32d));
    k = $urandom % 48;
    ref_key = 6'(k);
    adj_key = 6'(k);
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      host.rd(8'(i), rv);
      chk("reset value", rv, rstv[i]);
    end
    host.rd(8'h3f, rv);
    chk("unmapped", rv, 8'h00);
    chk("idle reset", {2'b00, idle_time}, 8'h18);
    $display("test reset values done");
    a = $urandom % 300;
    offs[0] = 8'h00;
    offs[1] = a > 255 ? 8'hff : 8'(a);
    host.wr(bfh_pkg::REG_CMD, bfh_pkg::CMD_AUTO_OFFSET);
    #1 chk("auto busy", {7'h00, auto_busy}, 8'h01);
    host.rd(bfh_pkg::REG_STATUS, rv);
    chk("status busy", rv, 8'h80);
    ref_sample(2'd0, 1000);
    ref_sample(2'd1, 1000 - a);
    ref_sample(2'd2, 1007);
    scan();
    chk("auto done", {7'h00, auto_busy}, 8'h00);
    host.rd(bfh_pkg::REG_TBL_A_BASE + 8'(k), rv);
    chk("table a", rv, offs[1]);
    host.rd(bfh_pkg::REG_TBL_B_BASE + 8'(k), rv);
    chk("table b clamp", rv, 8'h00);
    offs[2] = 8'($urandom);
    host.wr(bfh_pkg::REG_TBL_B_BASE + 8'(k), offs[2]);
    host.rd(bfh_pkg::REG_TBL_B_BASE + 8'(k), rv);
    chk("table b write", rv, offs[2]);
    $display("test offset tables done");
    for (m = 0; m < 4; m++)
    begin
      host.wr(bfh_pkg::REG_HOP_MODE, 8'(m));
      a = $urandom % 16;
      host.wr(bfh_pkg::REG_NOISE_THR, 8'(a));
      thr = 5 + 3 * a;
      lim = 3 + $urandom % 13;
      host.wr(bfh_pkg::REG_NOISE_LIM, 8'(lim));
      try_hop(lim, lim, thr - 1, 1'b0);
      try_hop(lim - 1, lim, thr, 1'b0);
      try_hop(0, lim, thr, 1'b0);
      try_hop(lim, 0, thr, 1'b0);
      cal_busy <= 1'b1;
      try_hop(lim, lim, thr, 1'b0);
      cal_busy <= 1'b0;
      for (i = 1; i <= 3; i++)
      begin
        try_hop(lim, lim, thr + i, m == 1 || m == 2);
        if (m == 1 || m == 2)
        begin
          chk("freq select", {6'h00, freq_sel}, 8'(i % 3));
          chk("idle time", {2'b00, idle_time}, rstv[i % 3 + 1]);
          host.rd(bfh_pkg::REG_STATUS, rv);
          chk("status", rv, {1'b0, 2'(i % 3), 5'h00});
        end
        if (m == 2)
          chk("offset", adj_offset, offs[i % 3]);
        if (m == 0)
          chk("fixed idle", {2'b00, idle_time}, 8'h18);
      end
      $display("test hop mode %0d done", m);
    end
    p = $urandom % 60;
    host.wr(bfh_pkg::REG_HOP_MODE, 8'h00);
    host.sweep_range(6'(p));
    host.wr(bfh_pkg::REG_HOP_MODE, 8'h03);
    h0 = hop_n;
    for (i = 1; i <= 4; i++)
    begin
      scan();
      chk("sweep idle", {2'b00, idle_time}, 8'(p + i % 4));
    end
    chk("sweep hops", 8'(hop_n - h0), 8'h00);
    host.close_block();
    host.rd(bfh_pkg::REG_CHECKSUM, rv);
    chk("checksum ignored", rv, 8'h00);
    $display("test sweep done");
    print_verdict();
  end
endmodule
`default_nettype wire
